// ==== src/usf_cfg.svh ====
`ifndef USF_CFG_SVH
`define USF_CFG_SVH
`define USF_OFF_STATUS 8'h00
`define USF_OFF_FRAME  8'h04
`define USF_OFF_CTRL   8'h08
`define USF_OFF_DATA   8'h0c
`define USF_OFF_BAUD   8'h10
`define USF_SEL_STATUS 3'h0
`define USF_SEL_FRAME  3'h1
`define USF_SEL_CTRL   3'h2
`define USF_SEL_DATA   3'h3
`define USF_SEL_BAUD   3'h4
`define USF_SEL_NONE   3'h7
`define USF_CTRL_TXON  7
`define USF_CTRL_RXON  6
`define USF_CTRL_RIE   2
`define USF_FRAME_GLOB 7
`define USF_FRAME_BRK  2
`define USF_STATUS_RST 8'h0b
`define USF_FRAME_RST  8'h00
`define USF_BAUD_RST   8'h00
`define USF_SUB_LAST   4'hf
`define USF_VOTE_A     4'h7
`define USF_VOTE_B     4'h8
`define USF_VOTE_C     4'h9
`define USF_BREAK_BITS 4'hd
`define USF_RESP_OKAY  2'h0
`define USF_RESP_SLVERR 2'h2
`endif

// ==== src/usf_pkg.sv ====
package usf_pkg;
  typedef struct packed {
    logic parityErr;
    logic noise;
    logic framingErr;
    logic overrun;
    logic rxIdle;
    logic rxAvail;
    logic txIdle;
    logic txEmpty;
  } usf_status_t;
  typedef struct packed {
    logic globalOn;
    logic nineBit;
    logic parityOn;
    logic parityOdd;
    logic twoStop;
    logic breakSend;
    logic rxNinth;
    logic txNinth;
  } usf_frame_t;
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } usf_word_t;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_STOP = 5'h08, TX_BRK = 5'h10
  } usf_tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
  } usf_rx_state_t;
endpackage

// ==== src/usf_baud_tick.sv ====
`timescale 1ns/10ps
`default_nettype none
module usf_baud_tick (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       ce,
  // Control
  input  wire logic       clear,
  input  wire logic [7:0] divisor,
  // Sample strobe, sixteen per bit
  output logic            tick
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (srst || clear) begin
      cnt_q <= 8'h00;
    end else if (ce) begin
      cnt_q <= (cnt_q == divisor) ? 8'h00 : cnt_q + 8'h01;
    end
  end

  assign tick = ce && !clear && (cnt_q == divisor);
endmodule // usf_baud_tick
`default_nettype wire

// ==== src/usf_uart.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "usf_cfg.svh"
// Overview of operation
// - Receiver idle low from start to stop
// - Buffered word sets available flag, interrupt
// - Parity, noise, framing flags set with available flag
// - Available clears after status, data read, empty
// - Transmitter idle set when empty, nothing queued
// - Idle cleared by status read, data write
// - Empty set when shifter takes character
// - Empty cleared by status read, data write
// - Transmitter enable sets empty flag
// - Global enable hands pins to transceiver
// - Disable discards buffer, resets baud counter
// - Disable clears transmit, receive enables, other flags; sets idle, empty
// - Disable aborts transfers, keeps configuration
// - Eight or nine data bits
// - Parity bit is last, not stored
// - Parity only while enabled
// - Odd or even parity select
// - One or two stop bits
// - Break low thirteen bits until cleared
// - Ninth bit via control bits
// - Least significant bit first at baud rate
// - Errors cleared by status then data access
// - Transmitter disable aborts and resets
module usf_uart
  import usf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial pins
  input  wire logic        rxIn,
  output logic             txOut,
  output logic             txOe,
  output logic             rxUse,
  // Receive interrupt request
  output logic             rxIrq
);
  usf_frame_t    frame_q;
  usf_status_t   stat;
  usf_tx_state_t txState_q;
  usf_rx_state_t rxState_q;
  usf_word_t     txBuf_q;
  usf_word_t     rxMem_q [2];
  usf_word_t     rxHead;
  usf_word_t     rxWord;
  logic        txOn_q, rxOn_q, rieOn_q;
  logic [7:0]  baud_q;
  logic        txEmpty_q, txIdle_q, rxAvail_q, parity_error_flag_q, nf_q, framing_error_flag_q, overrun_flag_q;
  logic        armRx_q, armTxE_q, armTxI_q;
  logic        awHeld_q, wHeld_q, wLane_q, bvalid_q, rvalid_q;
  logic [7:0]  awAddr_q, wLow_q, rdata_q;
  logic [1:0]  bresp_q, rresp_q;
  logic        awGot, wGot, wrFire, rdFire, wLane;
  logic [7:0]  wAddr, wByte, rdValue;
  logic [2:0]  wrSel, rdSel;
  logic        stRd, dataRd, dataWr, dataAcc, globalOn, txActive, rxActive, tick;
  logic        txFull_q, txLine_q, txTake, bitEndTx, bitEndRx;
  logic [8:0]  txSh_q, rxSh_q, rxAligned;
  logic [3:0]  txSub_q, txBitCnt_q, rxSub_q, rxBitCnt_q, nbLast;
  logic        rxMeta_q, rxSync_q, rxNoise_q, rxBit, rxUniform;
  logic [2:0]  vote_q;
  logic        rxWr_q, rxRd_q, rxDone, rxPush, rxOverEv, rxPop, rxParErr;
  logic [1:0]  rxCnt_q;

  function automatic logic [2:0] regIndex(input logic [7:0] a);
    case (a)
      `USF_OFF_STATUS: regIndex = `USF_SEL_STATUS;
      `USF_OFF_FRAME:  regIndex = `USF_SEL_FRAME;
      `USF_OFF_CTRL:   regIndex = `USF_SEL_CTRL;
      `USF_OFF_DATA:   regIndex = `USF_SEL_DATA;
      `USF_OFF_BAUD:   regIndex = `USF_SEL_BAUD;
      default:         regIndex = `USF_SEL_NONE;
    endcase
  endfunction

  function automatic logic [8:0] txFrame(input usf_word_t w, input usf_frame_t f);
    logic [8:0] b;
    b = f.nineBit ? {w.ninth, w.data} : {1'b0, w.data};
    if (f.parityOn && f.nineBit) begin
      b[8] = (^b[7:0]) ^ f.parityOdd;
    end else if (f.parityOn) begin
      b[7] = (^b[6:0]) ^ f.parityOdd;
    end
    return b;
  endfunction

  // Bus slave; write address and data may arrive in either order
  assign s_axi_awready = ce && !awHeld_q && !bvalid_q;
  assign s_axi_wready  = ce && !wHeld_q && !bvalid_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign awGot  = awHeld_q || s_axi_awvalid;
  assign wGot   = wHeld_q || s_axi_wvalid;
  assign wrFire = ce && awGot && wGot && !bvalid_q;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign wAddr  = awHeld_q ? awAddr_q : s_axi_awaddr;
  assign wByte  = wHeld_q ? wLow_q : s_axi_wdata[7:0];
  assign wLane  = wHeld_q ? wLane_q : s_axi_wstrb[0];
  assign wrSel  = regIndex(wAddr);
  assign rdSel  = regIndex(s_axi_araddr);
  assign stRd   = rdFire && (rdSel == `USF_SEL_STATUS);
  assign dataRd = rdFire && (rdSel == `USF_SEL_DATA);
  assign dataWr = wrFire && wLane && (wrSel == `USF_SEL_DATA);
  assign dataAcc = dataRd || dataWr;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wLow_q   <= 8'h00;
      wLane_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= `USF_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wLow_q  <= s_axi_wdata[7:0];
        wLane_q <= s_axi_wstrb[0];
      end
      if (wrFire) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wrSel == `USF_SEL_NONE) ? `USF_RESP_SLVERR : `USF_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (rdSel)
      `USF_SEL_STATUS: rdValue = stat;
      `USF_SEL_FRAME:  rdValue = {frame_q[7:2], rxHead.ninth, 1'b0};
      `USF_SEL_CTRL:   rdValue = {txOn_q, rxOn_q, 3'h0, rieOn_q, 2'h0};
      `USF_SEL_DATA:   rdValue = rxHead.data;
      `USF_SEL_BAUD:   rdValue = baud_q;
      default:         rdValue = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
      rresp_q  <= `USF_RESP_OKAY;
    end else if (ce) begin
      if (rdFire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rdValue;
        rresp_q  <= (rdSel == `USF_SEL_NONE) ? `USF_RESP_SLVERR : `USF_RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = {24'h0, rdata_q};

  // Configuration; disabling keeps all but transmit/receive enables and break
  assign globalOn = frame_q.globalOn;
  assign txActive = globalOn && txOn_q;
  assign rxActive = globalOn && rxOn_q;
  assign txOe     = txActive;
  assign rxUse    = rxActive;
  assign nbLast   = frame_q.nineBit ? 4'h8 : 4'h7;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      frame_q <= `USF_FRAME_RST;
      baud_q  <= `USF_BAUD_RST;
      txOn_q  <= 1'b0;
      rxOn_q  <= 1'b0;
      rieOn_q <= 1'b0;
    end else if (ce) begin
      if (wrFire && wLane && wrSel == `USF_SEL_FRAME) begin
        frame_q           <= wByte;
        frame_q.rxNinth   <= 1'b0;
        frame_q.breakSend <= wByte[`USF_FRAME_BRK] && wByte[`USF_FRAME_GLOB];
      end
      if (wrFire && wLane && wrSel == `USF_SEL_BAUD) begin
        baud_q <= wByte;
      end
      if (!globalOn) begin
        txOn_q <= 1'b0;
        rxOn_q <= 1'b0;
      end else if (wrFire && wLane && wrSel == `USF_SEL_CTRL) begin
        txOn_q <= wByte[`USF_CTRL_TXON];
        rxOn_q <= wByte[`USF_CTRL_RXON];
      end
      if (wrFire && wLane && wrSel == `USF_SEL_CTRL) begin
        rieOn_q <= wByte[`USF_CTRL_RIE];
      end
    end
  end

  // Baud counter restarts whenever the transceiver is disabled
  usf_baud_tick u_baud (
    .clk_sys (clk_sys),
    .srst    (srst),
    .ce      (ce),
    .clear   (!globalOn),
    .divisor (baud_q),
    .tick    (tick)
  );

  // Status-read arming for the two-step clear sequences
  always_ff @(posedge clk_sys) begin
    if (srst || !globalOn) begin
      armRx_q  <= 1'b0;
      armTxE_q <= 1'b0;
      armTxI_q <= 1'b0;
    end else if (ce) begin
      if (dataAcc) begin
        armRx_q <= 1'b0;
      end
      if (dataWr) begin
        armTxE_q <= 1'b0;
        armTxI_q <= 1'b0;
      end
      if (stRd) begin
        armRx_q  <= rxAvail_q || parity_error_flag_q || nf_q || framing_error_flag_q || overrun_flag_q;
        armTxE_q <= txEmpty_q;
        armTxI_q <= txIdle_q;
      end
    end
  end

  // Transmit holding register and its flags
  assign txTake = txActive && txFull_q && (txState_q == TX_IDLE);

  always_ff @(posedge clk_sys) begin
    if (srst || !txActive) begin
      txFull_q <= 1'b0;
      txBuf_q  <= '0;
    end else if (ce) begin
      if (dataWr) begin
        txFull_q <= 1'b1;
        txBuf_q  <= {frame_q.txNinth, wByte};
      end else if (txTake) begin
        txFull_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || !globalOn) begin
      txEmpty_q <= 1'b1;
      txIdle_q  <= 1'b1;
    end else if (ce) begin
      if (txTake || (wrFire && wLane && wrSel == `USF_SEL_CTRL && wByte[`USF_CTRL_TXON])) begin
        txEmpty_q <= 1'b1;
      end else if (dataWr && armTxE_q) begin
        txEmpty_q <= 1'b0;
      end
      // A write in flight is queued data, so idle may not be set over it
      if (txEmpty_q && !txFull_q && !dataWr && txState_q == TX_IDLE && !frame_q.breakSend) begin
        txIdle_q <= 1'b1;
      end else if (dataWr && armTxI_q) begin
        txIdle_q <= 1'b0;
      end
    end
  end

  // Transmit shifter
  assign bitEndTx = tick && (txSub_q == `USF_SUB_LAST);

  always_ff @(posedge clk_sys) begin
    if (srst || !txActive) begin
      txState_q  <= TX_IDLE;
      txSub_q    <= 4'h0;
      txBitCnt_q <= 4'h0;
      txSh_q     <= 9'h000;
      txLine_q   <= 1'b1;
    end else if (ce) begin
      if (tick) begin
        txSub_q <= txSub_q + 4'h1;
      end
      unique case (txState_q)
        TX_IDLE: begin
          txSub_q    <= 4'h0;
          txBitCnt_q <= 4'h0;
          txLine_q   <= 1'b1;
          if (txFull_q) begin
            txSh_q    <= txFrame(txBuf_q, frame_q);
            txState_q <= TX_START;
            txLine_q  <= 1'b0;
          end else if (frame_q.breakSend) begin
            txState_q <= TX_BRK;
            txLine_q  <= 1'b0;
          end
        end
        TX_START: begin
          if (bitEndTx) begin
            txState_q <= TX_DATA;
            txLine_q  <= txSh_q[0];
          end
        end
        TX_DATA: begin
          if (bitEndTx && txBitCnt_q == nbLast) begin
            txState_q  <= TX_STOP;
            txBitCnt_q <= 4'h0;
            txLine_q   <= 1'b1;
          end else if (bitEndTx) begin
            txSh_q     <= {1'b0, txSh_q[8:1]};
            txLine_q   <= txSh_q[1];
            txBitCnt_q <= txBitCnt_q + 4'h1;
          end
        end
        TX_STOP: begin
          if (bitEndTx && txBitCnt_q == {3'h0, frame_q.twoStop}) begin
            txState_q <= TX_IDLE;
          end else if (bitEndTx) begin
            txBitCnt_q <= txBitCnt_q + 4'h1;
          end
        end
        TX_BRK: begin
          if (bitEndTx && txBitCnt_q != `USF_BREAK_BITS) begin
            txBitCnt_q <= txBitCnt_q + 4'h1;
          end
          if (txBitCnt_q == `USF_BREAK_BITS && !frame_q.breakSend) begin
            txState_q <= TX_IDLE;
            txLine_q  <= 1'b1;
          end
        end
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  assign txOut = txLine_q;

  // Receive synchroniser and majority-vote bit sampler
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
    end else if (ce) begin
      rxMeta_q <= rxIn;
      rxSync_q <= rxMeta_q;
    end
  end

  assign bitEndRx  = tick && (rxSub_q == `USF_SUB_LAST);
  assign rxBit     = (vote_q[0] & vote_q[1]) | (vote_q[0] & vote_q[2]) | (vote_q[1] & vote_q[2]);
  assign rxUniform = (&vote_q) || !(|vote_q);

  always_ff @(posedge clk_sys) begin
    if (srst || !rxActive) begin
      rxState_q  <= RX_IDLE;
      rxSub_q    <= 4'h0;
      rxBitCnt_q <= 4'h0;
      rxSh_q     <= 9'h000;
      vote_q     <= 3'h7;
      rxNoise_q  <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        rxSub_q <= rxSub_q + 4'h1;
        if (rxSub_q == `USF_VOTE_A || rxSub_q == `USF_VOTE_B || rxSub_q == `USF_VOTE_C) begin
          vote_q <= {vote_q[1:0], rxSync_q};
        end
      end
      unique case (rxState_q)
        RX_IDLE: begin
          rxSub_q    <= 4'h0;
          rxBitCnt_q <= 4'h0;
          rxNoise_q  <= 1'b0;
          if (!rxSync_q) begin
            rxState_q <= RX_START;
          end
        end
        RX_START: begin
          if (bitEndRx) begin
            rxState_q <= rxBit ? RX_IDLE : RX_DATA;
            rxNoise_q <= !rxUniform;
          end
        end
        RX_DATA: begin
          if (bitEndRx) begin
            rxSh_q     <= {rxBit, rxSh_q[8:1]};
            rxNoise_q  <= rxNoise_q || !rxUniform;
            rxBitCnt_q <= rxBitCnt_q + 4'h1;
            if (rxBitCnt_q == nbLast) begin
              rxState_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (bitEndRx) begin
            rxState_q <= RX_IDLE;
          end
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  // Word assembly; the parity position is never stored
  assign rxAligned = frame_q.nineBit ? rxSh_q : {1'b0, rxSh_q[8:1]};
  assign rxParErr  = frame_q.parityOn && ((^rxAligned) != frame_q.parityOdd);
  always_comb begin
    rxWord.data  = rxAligned[7:0];
    rxWord.ninth = frame_q.nineBit && !frame_q.parityOn && rxAligned[8];
    if (frame_q.parityOn && !frame_q.nineBit) begin
      rxWord.data[7] = 1'b0;
    end
  end

  // Two-word receive buffer
  assign rxDone   = ce && rxActive && (rxState_q == RX_STOP) && bitEndRx;
  assign rxPush   = rxDone && (rxCnt_q != 2'h2);
  assign rxOverEv = rxDone && (rxCnt_q == 2'h2);
  assign rxPop    = ce && dataRd && (rxCnt_q != 2'h0);
  assign rxHead   = rxMem_q[rxRd_q];

  always_ff @(posedge clk_sys) begin
    if (srst || !rxActive) begin
      rxWr_q  <= 1'b0;
      rxMem_q <= '{default: '0};
      rxRd_q  <= 1'b0;
      rxCnt_q <= 2'h0;
    end else if (ce) begin
      if (rxPush) begin
        rxMem_q[rxWr_q] <= rxWord;
        rxWr_q          <= !rxWr_q;
      end
      if (rxPop) begin
        rxRd_q <= !rxRd_q;
      end
      rxCnt_q <= rxCnt_q + {1'b0, rxPush} - {1'b0, rxPop};
    end
  end

  // Receive flags; a new word wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst || !globalOn) begin
      rxAvail_q <= 1'b0;
      parity_error_flag_q    <= 1'b0;
      nf_q      <= 1'b0;
      framing_error_flag_q    <= 1'b0;
      overrun_flag_q    <= 1'b0;
    end else if (ce) begin
      if (rxPush) begin
        rxAvail_q <= 1'b1;
      end else if (!rxOn_q || (dataRd && armRx_q && rxCnt_q <= 2'h1)) begin
        rxAvail_q <= 1'b0;
      end
      if (rxPush && rxParErr) begin
        parity_error_flag_q <= 1'b1;
      end else if (dataAcc && armRx_q) begin
        parity_error_flag_q <= 1'b0;
      end
      if (rxPush && rxNoise_q) begin
        nf_q <= 1'b1;
      end else if (dataAcc && armRx_q) begin
        nf_q <= 1'b0;
      end
      if (rxPush && !rxBit) begin
        framing_error_flag_q <= 1'b1;
      end else if (dataAcc && armRx_q) begin
        framing_error_flag_q <= 1'b0;
      end
      if (rxOverEv) begin
        overrun_flag_q <= 1'b1;
      end else if (dataAcc && armRx_q) begin
        overrun_flag_q <= 1'b0;
      end
    end
  end

  assign stat  = {parity_error_flag_q, nf_q, framing_error_flag_q, overrun_flag_q, rxState_q == RX_IDLE, rxAvail_q, txIdle_q,
                  txEmpty_q};
  assign rxIrq = rxAvail_q && rieOn_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_rx_avail_cause: assert property ($rose(rxAvail_q) |-> $past(rxPush))
    else $error("available flag rose without a buffered word");
  a_err_with_avail: assert property ($rose(framing_error_flag_q) |-> rxAvail_q && $past(rxPush))
    else $error("framing flag set apart from available flag");
  a_rx_clear_seq: assert property ($fell(rxAvail_q) && globalOn && rxOn_q
    |-> $past(dataRd && armRx_q && rxCnt_q <= 2'h1))
    else $error("available flag cleared without the read sequence");
  a_tx_idle_line: assert property (txIdle_q && txActive && $past(txIdle_q) |-> txLine_q)
    else $error("transmit line low while idle");
  a_tx_empty_clear: assert property ($fell(txEmpty_q) |-> $past(dataWr && armTxE_q))
    else $error("empty flag cleared without the write sequence");
  a_tx_on_empty: assert property (ce && wrFire && wLane && wrSel == `USF_SEL_CTRL
    && wByte[`USF_CTRL_TXON] && globalOn |=> txEmpty_q)
    else $error("empty flag not set by transmitter enable");
  a_global_off: assert property (ce && !globalOn |=> !txOn_q && !rxOn_q
    && !frame_q.breakSend && stat == `USF_STATUS_RST)
    else $error("disabled state not reached");
  a_break_len: assert property ($past(txState_q == TX_BRK) && txState_q == TX_IDLE && txActive
    |-> $past(txBitCnt_q) == `USF_BREAK_BITS)
    else $error("break shorter than thirteen bits");
endmodule // usf_uart
`default_nettype wire

// ==== tb/usf_remote.sv ====
`timescale 1ns/10ps
`default_nettype none
module usf_remote (
  // Clock
  input  wire logic clk_sys,
  // Serial lines
  input  wire logic txLine,
  input  wire logic txOn,
  output logic      rxLine
);
  logic [8:0] got;
  int         frames = 0;
  initial rxLine = 1'b1;
  // Sixteen clocks a bit, divisor 0; line rests high after stop
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      rxLine <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (15) @(posedge clk_sys);
    end
  endtask
  // Mid-bit samples: eight bits, then the ninth bit, or the stop bit of eight-bit frames, in got[8]
  always @(negedge txLine) if (txOn === 1'b1) begin
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge clk_sys);
      got[i] = txLine;
    end
    frames++;
  end
endmodule // usf_remote
`default_nettype wire

// ==== tb/test_uart_status_and_frame_control.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "usf_cfg.svh"
module test_uart_status_and_frame_control
  import usf_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  s_axi_awaddr = '0;
  logic [7:0]  s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata;
  logic        txOut, txOe, rxUse, rxIrq, rxIn;
  logic [8:0]  v;
  int          error_cnt = 0;
  int          compares = 0;

  usf_uart dut (.clk_sys, .srst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxIn, .txOut, .txOe,
    .rxUse, .rxIrq);
  usf_remote remote (.clk_sys, .txLine(txOut), .txOn(txOe), .rxLine(rxIn));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    $display("[ERR] %0t wait timed out", $time);
    results();
  endtask
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Ready is looked at just before the edge that samples it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aT, wT, bT;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bT = 1'b0;
    for (int n = 0; n < 50 && !bT; n++) begin
      @(negedge clk_sys);
      aT = s_axi_awready === 1'b1;
      wT = s_axi_wready === 1'b1;
      bT = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (aT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
      if (bT) s_axi_bready <= 1'b0;
    end
    if (!bT) tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] d);
    logic aT, rT;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rT = 1'b0;
    for (int n = 0; n < 50 && !rT; n++) begin
      @(negedge clk_sys);
      aT = s_axi_arready === 1'b1;
      rT = s_axi_rvalid === 1'b1;
      d = {1'b0, s_axi_rdata[7:0]};
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (aT) s_axi_arvalid <= 1'b0;
      if (rT) s_axi_rready <= 1'b0;
    end
    if (!rT) tmo();
  endtask
  task automatic waitTx(input int f);
    for (int n = 0; n < 400 && remote.frames == f; n++) @(posedge clk_sys);
    if (remote.frames == f) tmo();
    // Lets the last stop bit finish before the status is read
    repeat (32) @(posedge clk_sys);
  endtask
  task automatic waitIrq();
    for (int n = 0; n < 400 && rxIrq !== 1'b1; n++) @(posedge clk_sys);
    if (rxIrq !== 1'b1) tmo();
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`USF_OFF_STATUS, v); chk(v, 9'h00b);
    rd(`USF_OFF_FRAME, v); chk(v, 9'h000);
    rd(8'h20, v); chk({7'h0, r}, {7'h0, `USF_RESP_SLVERR});
    wr(8'h20, 8'h00);
    chk({7'h0, r}, {7'h0, `USF_RESP_SLVERR});
    $display("test reset done");
    wr(`USF_OFF_BAUD, 8'h00);
    chk({7'h0, r}, 9'h000);
    wr(`USF_OFF_FRAME, 8'h80);
    wr(`USF_OFF_CTRL, 8'hc4);
    rd(`USF_OFF_CTRL, v); chk(v, 9'h0c4);
    chk({7'h0, txOe, rxUse}, 9'h003);
    rd(`USF_OFF_STATUS, v); chk(v, 9'h00b);
    wr(`USF_OFF_DATA, 8'ha5);
    rd(`USF_OFF_STATUS, v); chk({8'h0, v[1]}, 9'h000);
    waitTx(0); chk(remote.got, 9'h1a5);
    rd(`USF_OFF_STATUS, v); chk(v, 9'h00b);
    $display("test transmit done");
    fork
      remote.send(8'h3c);
      begin
        repeat (60) @(posedge clk_sys);
        rd(`USF_OFF_STATUS, v); chk({8'h0, v[3]}, 9'h000);
      end
    join
    waitIrq(); rd(`USF_OFF_STATUS, v); chk(v, 9'h00f);
    rd(`USF_OFF_DATA, v); chk(v, 9'h03c);
    rd(`USF_OFF_STATUS, v); chk(v, 9'h00b);
    chk({8'h0, rxIrq}, 9'h000);
    $display("test receive done");
    // Ninth bit sent is the write-only bit; the partner's stop bit lands in the ninth place
    wr(`USF_OFF_FRAME, 8'hc0);
    rd(`USF_OFF_STATUS, v);
    wr(`USF_OFF_DATA, 8'h5a);
    waitTx(1); chk(remote.got, 9'h05a);
    remote.send(8'h3c);
    waitIrq(); rd(`USF_OFF_FRAME, v); chk(v, 9'h0c2);
    rd(`USF_OFF_STATUS, v); chk(v, 9'h00f);
    rd(`USF_OFF_DATA, v); chk(v, 9'h03c);
    $display("test nine bit done");
    // Odd parity over seven data bits takes the eighth place
    wr(`USF_OFF_FRAME, 8'hb0);
    rd(`USF_OFF_STATUS, v);
    wr(`USF_OFF_DATA, 8'h05);
    waitTx(2); chk(remote.got, 9'h185);
    remote.send(8'h03);
    waitIrq(); rd(`USF_OFF_STATUS, v); chk(v, 9'h08f);
    rd(`USF_OFF_DATA, v); chk(v, 9'h003);
    rd(`USF_OFF_STATUS, v); chk(v, 9'h00b);
    $display("test parity done");
    // Third word finds both buffer places taken and is dropped
    remote.send(8'h01);
    remote.send(8'h01);
    remote.send(8'h01);
    repeat (20) @(posedge clk_sys);
    rd(`USF_OFF_STATUS, v); chk(v, 9'h01f);
    rd(`USF_OFF_DATA, v); chk(v, 9'h001);
    rd(`USF_OFF_STATUS, v); chk(v, 9'h00f);
    $display("test overrun done");
    wr(`USF_OFF_FRAME, 8'h30);
    rd(`USF_OFF_CTRL, v); chk(v, 9'h004);
    rd(`USF_OFF_FRAME, v); chk(v, 9'h030);
    rd(`USF_OFF_STATUS, v); chk(v, 9'h00b);
    chk({7'h0, txOe, rxUse}, 9'h000);
    $display("test disable done");
    results();
  end
endmodule // test_uart_status_and_frame_control
`default_nettype wire
